// *** psp_port.sv ***
// parallel slave port with general port mode and axi4-lite register access
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Function
// (RULE1) data port acts as slave port only while slave_mode_select is set
// (RULE2) external processor reads and writes asynchronously via read and write strobes
// (RULE3) slave mode makes strobe pins 0,1,2 read, write and chip-select inputs
// (RULE4) software sets strobe pin directions to input before using slave mode
// (RULE5) two latches at one address: cpu writes outgoing, reads incoming
// (RULE6) in slave mode data direction register is ignored; strobes set direction
// (RULE7) input_full_flag sets on external write, clears on cpu read, read-only
// (RULE8) output_full_flag sets on cpu write, clears on external read
// (RULE9) external write while input full sets overflow, keeps first word
// (RULE10) outside slave mode both full flags are held clear
// (RULE11) overflow flag stays set, even outside slave mode, until software clears
// (RULE12) each completed external read or write sets slave_port_irq_flag
// (RULE13) irq flag cleared only by software; enable bit gates the interrupt
// (RULE14) read strobe low with chip select low is an external read
// (RULE15) write strobe low with chip select low is an external write
// (RULE16) chip select high makes the port ignore both strobes
// (RULE17) data pins driven from outgoing latch only while select and read low
// (RULE18) strobes synchronised; data captured at write end; flags update after strobe
module psp_port (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite slave
	input  wire logic [psp_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [psp_pkg::BUS_W-1:0]   s_axi_wdata,
	input  wire logic [psp_pkg::BUS_W/8-1:0] s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [psp_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [psp_pkg::BUS_W-1:0]        s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// data port pins
	input  wire logic [psp_pkg::DATA_W-1:0]  data_in,
	output logic      [psp_pkg::DATA_W-1:0]  data_out,
	output logic      [psp_pkg::DATA_W-1:0]  data_oe_n,
	// strobe port pins
	input  wire logic [psp_pkg::TRIS_W-1:0]  ctrl_in,
	output logic      [psp_pkg::TRIS_W-1:0]  ctrl_out,
	output logic      [psp_pkg::TRIS_W-1:0]  ctrl_oe_n,
	// interrupt
	output logic                             irq
);

	////////////////////////////////////////////////////////////////////////////////
	// address decode shared by read and write paths
	function automatic logic reg_hit(
		input logic [psp_pkg::ADDR_W-1:0] addr,
		input logic [psp_pkg::IDX_W-1:0]  idx
	);
		return addr[psp_pkg::ADDR_W-1:psp_pkg::IDX_LSB] == idx;
	endfunction

	// mapped when any register index matches
	function automatic logic reg_mapped(input logic [psp_pkg::ADDR_W-1:0] addr);
		return reg_hit(addr, psp_pkg::IDX_DATA) | reg_hit(addr, psp_pkg::IDX_STROBE)
			| reg_hit(addr, psp_pkg::IDX_FLAGS) | reg_hit(addr, psp_pkg::IDX_DDR)
			| reg_hit(addr, psp_pkg::IDX_TRIS_E) | reg_hit(addr, psp_pkg::IDX_ENABLES)
			| reg_hit(addr, psp_pkg::IDX_FLAG_CLR);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// synchronised pins
	localparam int SYNC_W = psp_pkg::TRIS_W + psp_pkg::DATA_W;

	logic [SYNC_W-1:0]          sync_out;
	logic [psp_pkg::DATA_W-1:0] sy_data;
	logic [psp_pkg::TRIS_W-1:0] sy_ctrl;

	// strobes and data share one latency so data lines up with the strobe end
	psp_sync #(
		.WIDTH   (SYNC_W),
		.RST_VAL ({psp_pkg::RST_CTRL_IN, psp_pkg::RST_ZERO})
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({ctrl_in, data_in}),
		.stable   (sync_out)
	); // RULE2 RULE18

	assign sy_data = sync_out[psp_pkg::DATA_W-1:0];
	assign sy_ctrl = sync_out[SYNC_W-1:psp_pkg::DATA_W];

	////////////////////////////////////////////////////////////////////////////////
	// bus state
	logic                        aw_held;
	logic [psp_pkg::ADDR_W-1:0]  aw_addr;
	logic                        w_held;
	logic [psp_pkg::BUS_W-1:0]   w_data;
	logic [psp_pkg::BUS_W/8-1:0] w_strb;
	logic                        bvalid_q;
	logic [1:0]                  bresp_q;
	logic                        rvalid_q;
	logic [psp_pkg::BUS_W-1:0]   rdata_q;
	logic [1:0]                  rresp_q;

	logic                        next_aw_held;
	logic [psp_pkg::ADDR_W-1:0]  next_aw_addr;
	logic                        next_w_held;
	logic [psp_pkg::BUS_W-1:0]   next_w_data;
	logic [psp_pkg::BUS_W/8-1:0] next_w_strb;
	logic                        next_bvalid;
	logic [1:0]                  next_bresp;
	logic                        next_rvalid;
	logic [psp_pkg::BUS_W-1:0]   next_rdata;
	logic [1:0]                  next_rresp;

	// core state
	logic [psp_pkg::DATA_W-1:0]  out_latch;
	logic [psp_pkg::DATA_W-1:0]  in_latch;
	logic                        input_full_flag;
	logic                        output_full_flag;
	logic                        input_overflow_flag;
	logic                        mode;
	logic [psp_pkg::TRIS_W-1:0]  tris_e;
	logic [psp_pkg::DATA_W-1:0]  ddr_d;
	logic [psp_pkg::TRIS_W-1:0]  pe_latch;
	logic                        irq_flag;
	logic                        irq_en;
	logic                        rd_prev;
	logic                        wr_prev;

	logic [psp_pkg::DATA_W-1:0]  next_out_latch;
	logic [psp_pkg::DATA_W-1:0]  next_in_latch;
	logic                        next_ibf;
	logic                        next_obf;
	logic                        next_input_overflow_flag;
	logic                        next_mode;
	logic [psp_pkg::TRIS_W-1:0]  next_tris_e;
	logic [psp_pkg::DATA_W-1:0]  next_ddr_d;
	logic [psp_pkg::TRIS_W-1:0]  next_pe_latch;
	logic                        next_irq_flag;
	logic                        next_irq_en;
	logic                        next_rd_prev;
	logic                        next_wr_prev;

	// shared strobes between the bus and the core
	logic                        wr_go;
	logic                        ar_go;
	logic                        sw_wr;
	logic [psp_pkg::DATA_W-1:0]  sw_byte;
	logic                        rd_now;
	logic                        wr_now;
	logic                        rd_end;
	logic                        wr_end;
	logic                        cpu_rd_data;

	////////////////////////////////////////////////////////////////////////////////
	// bus handshakes; one write and one read at a time
	assign s_axi_awready = !aw_held && !bvalid_q;
	assign s_axi_wready  = !w_held && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	assign wr_go   = aw_held && w_held && !bvalid_q;
	assign ar_go   = s_axi_arvalid && !rvalid_q;
	assign sw_wr   = wr_go && w_strb[0];
	assign sw_byte = w_data[psp_pkg::DATA_W-1:0];

	// bus next state: address and data in either order, answer after both
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid_q;
		next_bresp   = bresp_q;
		next_rvalid  = rvalid_q;
		next_rdata   = rdata_q;
		next_rresp   = rresp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_go) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = reg_mapped(aw_addr) ? psp_pkg::RESP_OKAY : psp_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (ar_go) begin
			next_rvalid = 1'b1;
			next_rresp  = psp_pkg::RESP_OKAY;
			next_rdata  = '0;
			case (1'b1)
				reg_hit(s_axi_araddr, psp_pkg::IDX_DATA): begin
					// incoming latch in slave mode, pin levels otherwise
					next_rdata[psp_pkg::DATA_W-1:0] = mode ? in_latch : sy_data; // RULE5
				end
				reg_hit(s_axi_araddr, psp_pkg::IDX_STROBE): begin
					next_rdata[psp_pkg::TRIS_W-1:0] = sy_ctrl;
				end
				reg_hit(s_axi_araddr, psp_pkg::IDX_FLAGS): begin
					next_rdata[psp_pkg::BIT_IRQ] = irq_flag;
				end
				reg_hit(s_axi_araddr, psp_pkg::IDX_DDR): begin
					next_rdata[psp_pkg::DATA_W-1:0] = ddr_d;
				end
				reg_hit(s_axi_araddr, psp_pkg::IDX_TRIS_E): begin
					next_rdata[psp_pkg::BIT_IBF]  = input_full_flag;
					next_rdata[psp_pkg::BIT_OBF]  = output_full_flag;
					next_rdata[psp_pkg::BIT_INPUT_OVERFLOW_FLAG] = input_overflow_flag;
					next_rdata[psp_pkg::BIT_MODE] = mode;
					next_rdata[psp_pkg::TRIS_W-1:0] = tris_e;
				end
				reg_hit(s_axi_araddr, psp_pkg::IDX_ENABLES): begin
					next_rdata[psp_pkg::BIT_IRQ] = irq_en;
				end
				reg_hit(s_axi_araddr, psp_pkg::IDX_FLAG_CLR): begin
					next_rdata = '0; // write-only, reads zero
				end
				default: begin
					next_rresp = psp_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held  <= 1'b0;
			aw_addr  <= '0;
			w_held   <= 1'b0;
			w_data   <= '0;
			w_strb   <= '0;
			bvalid_q <= 1'b0;
			bresp_q  <= psp_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= psp_pkg::RESP_OKAY;
		end else begin
			aw_held  <= next_aw_held;
			aw_addr  <= next_aw_addr;
			w_held   <= next_w_held;
			w_data   <= next_w_data;
			w_strb   <= next_w_strb;
			bvalid_q <= next_bvalid;
			bresp_q  <= next_bresp;
			rvalid_q <= next_rvalid;
			rdata_q  <= next_rdata;
			rresp_q  <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// external strobe decode on synchronised levels; select high masks both
	assign rd_now = mode && !sy_ctrl[psp_pkg::PIN_CS] && !sy_ctrl[psp_pkg::PIN_RD]; // RULE14 RULE16
	assign wr_now = mode && !sy_ctrl[psp_pkg::PIN_CS] && !sy_ctrl[psp_pkg::PIN_WR]; // RULE15 RULE16
	assign rd_end = rd_prev && !rd_now; // RULE18
	assign wr_end = wr_prev && !wr_now; // RULE18
	assign cpu_rd_data = ar_go && mode && reg_hit(s_axi_araddr, psp_pkg::IDX_DATA);

	// core next state; every hardware set wins over a software clear in the same cycle
	always_comb begin
		next_out_latch = out_latch;
		next_in_latch  = in_latch;
		next_ibf       = input_full_flag;
		next_obf       = output_full_flag;
		next_input_overflow_flag      = input_overflow_flag;
		next_mode      = mode;
		next_tris_e    = tris_e;
		next_ddr_d     = ddr_d;
		next_pe_latch  = pe_latch;
		next_irq_flag  = irq_flag;
		next_irq_en    = irq_en;
		next_rd_prev   = rd_now;
		next_wr_prev   = wr_now;
		// software writes
		if (sw_wr && reg_hit(aw_addr, psp_pkg::IDX_DATA)) begin
			next_out_latch = sw_byte; // RULE5
		end
		if (sw_wr && reg_hit(aw_addr, psp_pkg::IDX_STROBE)) begin
			next_pe_latch = sw_byte[psp_pkg::TRIS_W-1:0];
		end
		if (sw_wr && reg_hit(aw_addr, psp_pkg::IDX_DDR)) begin
			next_ddr_d = sw_byte;
		end
		if (sw_wr && reg_hit(aw_addr, psp_pkg::IDX_TRIS_E)) begin
			// full flags are not writable
			next_input_overflow_flag   = sw_byte[psp_pkg::BIT_INPUT_OVERFLOW_FLAG]; // RULE7 RULE11
			next_mode   = sw_byte[psp_pkg::BIT_MODE]; // RULE1
			next_tris_e = sw_byte[psp_pkg::TRIS_W-1:0];
		end
		if (sw_wr && reg_hit(aw_addr, psp_pkg::IDX_ENABLES)) begin
			next_irq_en = sw_byte[psp_pkg::BIT_IRQ];
		end
		if (sw_wr && reg_hit(aw_addr, psp_pkg::IDX_FLAG_CLR) && sw_byte[psp_pkg::BIT_IRQ]) begin
			next_irq_flag = 1'b0; // RULE13
		end
		// cpu read of the incoming latch frees it
		if (cpu_rd_data) begin
			next_ibf = 1'b0; // RULE7
		end
		// cpu write of the outgoing latch in slave mode
		if (mode && sw_wr && reg_hit(aw_addr, psp_pkg::IDX_DATA)) begin
			next_obf = 1'b1; // RULE8
		end
		// external read finished
		if (rd_end) begin
			if (!(sw_wr && reg_hit(aw_addr, psp_pkg::IDX_DATA))) begin
				next_obf = 1'b0; // RULE8
			end
			next_irq_flag = 1'b1; // RULE12
		end
		// external write finished; a word read in this cycle makes room
		if (wr_end) begin
			if (input_full_flag && !cpu_rd_data) begin
				next_input_overflow_flag = 1'b1; // RULE9
			end else begin
				next_in_latch = sy_data; // RULE18
				next_ibf      = 1'b1; // RULE7
			end
			next_irq_flag = 1'b1; // RULE12
		end
		// outside slave mode the full flags stay clear; overflow persists
		if (!mode) begin
			next_ibf = 1'b0; // RULE10
			next_obf = 1'b0; // RULE10
		end
	end

	// core registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_latch <= psp_pkg::RST_ZERO;
			in_latch  <= psp_pkg::RST_ZERO;
			input_full_flag       <= 1'b0;
			output_full_flag       <= 1'b0;
			input_overflow_flag      <= 1'b0;
			mode      <= 1'b0;
			tris_e    <= psp_pkg::RST_TRIS_E[psp_pkg::TRIS_W-1:0];
			ddr_d     <= psp_pkg::RST_DDR;
			pe_latch  <= '0;
			irq_flag  <= 1'b0;
			irq_en    <= 1'b0;
			rd_prev   <= 1'b0;
			wr_prev   <= 1'b0;
		end else begin
			out_latch <= next_out_latch;
			in_latch  <= next_in_latch;
			input_full_flag       <= next_ibf;
			output_full_flag       <= next_obf;
			input_overflow_flag      <= next_input_overflow_flag;
			mode      <= next_mode;
			tris_e    <= next_tris_e;
			ddr_d     <= next_ddr_d;
			pe_latch  <= next_pe_latch;
			irq_flag  <= next_irq_flag;
			irq_en    <= next_irq_en;
			rd_prev   <= next_rd_prev;
			wr_prev   <= next_wr_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin drive: in slave mode the live strobes steer the data bus, not ddr_d
	assign data_out  = out_latch;
	assign data_oe_n = mode
		? {psp_pkg::DATA_W{ctrl_in[psp_pkg::PIN_CS] | ctrl_in[psp_pkg::PIN_RD]}} // RULE6 RULE17
		: ddr_d;
	// strobe pins follow their direction bits; software keeps them inputs
	assign ctrl_out  = pe_latch;
	assign ctrl_oe_n = tris_e; // RULE3 RULE4

	// level interrupt while the flag is set and enabled
	assign irq = irq_flag && irq_en; // RULE13

endmodule

// *** psp_pkg.sv ***
// constants for the parallel slave port: register indexes, fields, resets, responses
package psp_pkg;

	// register index width; byte address is four times the index
	localparam int IDX_W  = 10;
	localparam int ADDR_W = IDX_W + 2;
	localparam int IDX_LSB = 2;

	// register indexes
	localparam logic [IDX_W-1:0] IDX_DATA     = 10'h008; // parallel_data_latch
	localparam logic [IDX_W-1:0] IDX_STROBE   = 10'h009; // strobe_pin_port
	localparam logic [IDX_W-1:0] IDX_FLAGS    = 10'h00c; // peripheral_flags_one
	localparam logic [IDX_W-1:0] IDX_DDR      = 10'h088; // data_direction_register
	localparam logic [IDX_W-1:0] IDX_TRIS_E   = 10'h089; // strobe_direction_and_status
	localparam logic [IDX_W-1:0] IDX_ENABLES  = 10'h08c; // peripheral_enables_one
	localparam logic [IDX_W-1:0] IDX_FLAG_CLR = 10'h08d; // write-one-to-clear for flags

	// strobe_direction_and_status fields
	localparam int BIT_IBF  = 7;
	localparam int BIT_OBF  = 6;
	localparam int BIT_INPUT_OVERFLOW_FLAG = 5;
	localparam int BIT_MODE = 4;
	localparam int TRIS_W   = 3;

	// peripheral flag and enable field
	localparam int BIT_IRQ = 7;

	// control pin positions on the strobe port
	localparam int PIN_RD = 0;
	localparam int PIN_WR = 1;
	localparam int PIN_CS = 2;

	// widths
	localparam int DATA_W = 8;
	localparam int BUS_W  = 32;

	// reset values
	localparam logic [DATA_W-1:0] RST_TRIS_E  = 8'h07;
	localparam logic [DATA_W-1:0] RST_DDR     = 8'hff;
	localparam logic [DATA_W-1:0] RST_ZERO    = 8'h00;
	localparam logic [TRIS_W-1:0] RST_CTRL_IN = 3'h7;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** psp_sync.sv ***
// three-stage synchroniser that accepts a level once stages two and three agree
`timescale 1ns/10ps

module psp_sync #(
	parameter int               WIDTH   = 11,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] stable
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_stable;

	////////////////////////////////////////////////////////////////////////////////
	// per bit: accept the new level only when the later stages agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			assign next_stable[i] = (stage2[i] == stage3[i]) ? stage3[i] : stable[i];
		end
	endgenerate

	// stage registers; stage1 feeds stage2 only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= RST_VAL;
			stage2 <= RST_VAL;
			stage3 <= RST_VAL;
			stable <= RST_VAL;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			stable <= next_stable;
		end
	end

endmodule

// *** psp_port_props.sv ***
// concurrent checks on the parallel slave port pins
`timescale 1ns/10ps

module psp_port_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic [7:0]  data_out,
	input wire logic [7:0]  data_oe_n,
	input wire logic [2:0]  ctrl_in,
	input wire logic        irq
);
	logic       has_aw;
	logic       has_w;
	logic       mode;
	logic [9:0] widx;
	logic [7:0] wd;

	// shadow of the slave mode bit, updated the edge after both write halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			has_aw <= 1'b0;
			has_w  <= 1'b0;
			mode   <= 1'b0;
		end else if (has_aw && has_w) begin
			has_aw <= 1'b0;
			has_w  <= 1'b0;
			if (widx == psp_pkg::IDX_TRIS_E) begin
				mode <= wd[psp_pkg::BIT_MODE];
			end
		end else begin
			if (s_axi_awvalid && s_axi_awready) has_aw <= 1'b1;
			if (s_axi_wvalid && s_axi_wready) has_w <= 1'b1;
		end
	end

	// capture of the write address and low data byte
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) widx <= s_axi_awaddr[11:2];
		if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_oe_read;
		mode && !ctrl_in[2] && !ctrl_in[0] |-> data_oe_n == 8'h00;
	endproperty
	a_oe_read: assert property (p_oe_read) else $error("pins not driven in read");
	property p_oe_idle;
		mode && (ctrl_in[2] || ctrl_in[0]) |-> data_oe_n == 8'hff;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("pins driven while idle");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late or wide");
	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##1 !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer timing wrong");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_irq_fall;
		$fell(irq) |-> s_axi_bvalid;
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
	property p_out_latch;
		$changed(data_out) |-> s_axi_bvalid;
	endproperty
	a_out_latch: assert property (p_out_latch) else $error("out latch moved alone");

	cover property (mode && !ctrl_in[2] && !ctrl_in[0]);
	cover property ($rose(irq));
	cover property (s_axi_rvalid && s_axi_rresp == psp_pkg::RESP_SLVERR);
endmodule

bind psp_port psp_port_props u_psp_port_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.data_out(data_out), .data_oe_n(data_oe_n), .ctrl_in(ctrl_in), .irq(irq)
);

// *** psp_ext_host.sv ***
// model of the external 8-bit processor on the data and strobe pins
`timescale 1ns/10ps

module psp_ext_host (
	input  wire logic       aclk,
	input  wire logic [7:0] data_out,
	input  wire logic [7:0] data_oe_n,
	output logic      [7:0] data_in,
	output logic      [2:0] ctrl_in
);
	logic [7:0] host_val;

	// pin level: device where its enable is low, host value elsewhere
	always_comb data_in = (~data_oe_n & data_out) | (data_oe_n & host_val);

	initial begin
		ctrl_in  = 3'h7;
		host_val = 8'h00;
	end

	// one strobe of six cycles; released bus shows the inverse of its last value
	task automatic ext_cycle(input logic sel, input logic wr, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge aclk);
		ctrl_in <= {~sel, ~wr, wr};
		if (wr) host_val <= d;
		repeat (6) @(posedge aclk);
		q = data_in;
		ctrl_in <= 3'h7;
		repeat (2) @(posedge aclk);
		host_val <= ~host_val;
		repeat (6) @(posedge aclk);
	endtask
endmodule

// *** tb_parallel_slave_port.sv ***
// self-checking bench for the parallel slave port
`timescale 1ns/10ps

module tb_parallel_slave_port;
	localparam logic [1:0] OK  = psp_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = psp_pkg::RESP_SLVERR;
	logic        aclk, aresetn, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  data_in, data_out, data_oe_n, q;
	logic [2:0]  ctrl_in, ctrl_out, ctrl_oe_n;
	int          failures, checked;

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	psp_port u_psp_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .ctrl_in(ctrl_in), .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n),
		.irq(irq));

	psp_ext_host u_psp_ext_host (.aclk(aclk), .data_out(data_out), .data_oe_n(data_oe_n),
		.data_in(data_in), .ctrl_in(ctrl_in));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("counts: %0d failures, %0d checked", failures, checked);
		if (failures == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// register write, address and data offered together, response judged
	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a, w, b;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			a = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge aclk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
		check({30'h0, r}, {30'h0, er});
	endtask

	// register read, data and response judged
	task automatic rd(input logic [9:0] idx, input logic [7:0] exp, input logic [1:0] er);
		logic a, b;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			a = arvalid && arready;
			b = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (a) arvalid <= 1'b0;
		end while (!b);
		rready <= 1'b0;
		check(d, {24'h0, exp});
		check({30'h0, r}, {30'h0, er});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_unmapped;
		rd(psp_pkg::IDX_TRIS_E, 8'h07, OK);
		rd(psp_pkg::IDX_FLAGS, 8'h00, OK);
		rd(psp_pkg::IDX_ENABLES, 8'h00, OK);
		rd(psp_pkg::IDX_DDR, 8'hff, OK);
		wr(10'h001, 8'h55, ERR);
		rd(10'h001, 8'h00, ERR);
	endtask

	task automatic t_io_mode;
		wr(psp_pkg::IDX_DDR, 8'h0f, OK);
		check({24'h0, data_oe_n}, 32'h0f);
		u_psp_ext_host.ext_cycle(1'b1, 1'b1, 8'h3c, q);
		rd(psp_pkg::IDX_TRIS_E, 8'h07, OK);
		rd(psp_pkg::IDX_FLAGS, 8'h00, OK);
		wr(psp_pkg::IDX_DATA, 8'h5a, OK);
		rd(psp_pkg::IDX_TRIS_E, 8'h07, OK);
		check({24'h0, data_out}, 32'h5a);
		wr(psp_pkg::IDX_STROBE, 8'h05, OK);
		check({29'h0, ctrl_out}, 32'h5);
		rd(psp_pkg::IDX_STROBE, 8'h07, OK);
		rd(psp_pkg::IDX_DATA, 8'h53, OK);
	endtask

	task automatic t_ext_write;
		wr(psp_pkg::IDX_TRIS_E, 8'h17, OK);
		check({29'h0, ctrl_oe_n}, 32'h7);
		check({24'h0, data_oe_n}, 32'hff);
		u_psp_ext_host.ext_cycle(1'b1, 1'b1, 8'ha5, q);
		rd(psp_pkg::IDX_TRIS_E, 8'h97, OK);
		rd(psp_pkg::IDX_FLAGS, 8'h80, OK);
		check({31'h0, irq}, 32'h0);
		wr(psp_pkg::IDX_ENABLES, 8'h80, OK);
		check({31'h0, irq}, 32'h1);
		u_psp_ext_host.ext_cycle(1'b1, 1'b1, 8'h3c, q);
		rd(psp_pkg::IDX_TRIS_E, 8'hb7, OK);
		rd(psp_pkg::IDX_DATA, 8'ha5, OK);
		rd(psp_pkg::IDX_TRIS_E, 8'h37, OK);
		wr(psp_pkg::IDX_FLAGS, 8'h00, OK);
		check({31'h0, irq}, 32'h1);
		wr(psp_pkg::IDX_FLAG_CLR, 8'h80, OK);
		check({31'h0, irq}, 32'h0);
		wr(psp_pkg::IDX_TRIS_E, 8'hf7, OK);
		rd(psp_pkg::IDX_TRIS_E, 8'h37, OK);
		wr(psp_pkg::IDX_TRIS_E, 8'h27, OK);
		rd(psp_pkg::IDX_TRIS_E, 8'h27, OK);
		wr(psp_pkg::IDX_TRIS_E, 8'h17, OK);
		rd(psp_pkg::IDX_TRIS_E, 8'h17, OK);
	endtask

	task automatic t_ext_read;
		wr(psp_pkg::IDX_DATA, 8'h69, OK);
		rd(psp_pkg::IDX_TRIS_E, 8'h57, OK);
		u_psp_ext_host.ext_cycle(1'b1, 1'b0, 8'h00, q);
		check({24'h0, q}, 32'h69);
		rd(psp_pkg::IDX_TRIS_E, 8'h17, OK);
		rd(psp_pkg::IDX_FLAGS, 8'h80, OK);
		wr(psp_pkg::IDX_FLAG_CLR, 8'h80, OK);
		u_psp_ext_host.ext_cycle(1'b0, 1'b1, 8'h11, q);
		u_psp_ext_host.ext_cycle(1'b0, 1'b0, 8'h00, q);
		rd(psp_pkg::IDX_TRIS_E, 8'h17, OK);
		rd(psp_pkg::IDX_FLAGS, 8'h00, OK);
		wr(psp_pkg::IDX_DATA, 8'h42, OK);
		wr(psp_pkg::IDX_TRIS_E, 8'h07, OK);
		rd(psp_pkg::IDX_TRIS_E, 8'h07, OK);
		wr(psp_pkg::IDX_TRIS_E, 8'h17, OK);
		rd(psp_pkg::IDX_TRIS_E, 8'h17, OK);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		failures = 0;
		checked = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_unmapped;
		t_io_mode;
		t_ext_write;
		t_ext_read;
		finish_test;
	end

	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		finish_test;
	end
endmodule
